// file: bench/bus_card_checker.sv
// Port-level assertions for the bus card decode block.
`timescale 1ns/100ps
`default_nettype none
module bus_card_checker
  import bus_card_pkg::*;
#(
  parameter logic [7:0] SPI_DIVIDE = 8'h3E
) (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        masterSlaveSelect,
  input wire logic        shadowKillSourceSelect,
  input wire logic [7:0]  blockRamEnable,
  input wire logic [7:0]  blockRomEnable,
  input wire logic [7:0]  ioWindowBaseSelect,
  input wire logic [15:0] busAddress,
  input wire logic        busMemRead,
  input wire logic        busMemWrite,
  input wire logic        busIoRead,
  input wire logic        busIoWrite,
  input wire logic [7:0]  busDataIn,
  input wire logic        ramSelect,
  input wire logic        ramWrite,
  input wire logic        romSelect,
  input wire logic [14:0] memAddress,
  input wire logic        ioExternal,
  input wire logic        parallelOutputStrobe,
  input wire logic        spiCardSelectN,
  input wire logic        processorHold
);
  // ==========================================================================
  // Reference kill state and checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic       killSeen;
  logic       csWr;
  logic [2:0] blk;
  assign blk = busAddress[15:13];
  assign csWr = busIoWrite && ioWindowBaseSelect[busAddress[7:5]] && busAddress[4:0] == 5'h11;
  // Kept apart from the design so a kill that never sticks is caught.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) killSeen <= 1'b0;
    else if (csWr && !busDataIn[0] && !shadowKillSourceSelect) killSeen <= 1'b1;
  end
  sequence portWr;
    busIoWrite && ioWindowBaseSelect[busAddress[7:5]] && busAddress[4:0] == 5'h18;
  endsequence
  AST_HOLD: assert property (processorHold == !$past(masterSlaveSelect))
    else $error("hold wrong");
  AST_RAM_ONLY: assert property ((busMemRead || busMemWrite) && blockRamEnable[blk] &&
    !blockRomEnable[blk] |=> ramSelect && !romSelect && ramWrite == $past(busMemWrite))
    else $error("ram block wrong");
  AST_ROM_WRITE: assert property (busMemWrite && !blockRamEnable[blk] &&
    blockRomEnable[blk] |=> ramWrite && !romSelect) else $error("rom write wrong");
  AST_SHADOW: assert property (busMemRead && blockRamEnable[blk] && blockRomEnable[blk] &&
    !shadowKillSourceSelect |=> romSelect != $past(killSeen)) else $error("shadow wrong");
  AST_MIRROR: assert property (busMemRead |=> memAddress == $past(busAddress[14:0]))
    else $error("mirror wrong");
  AST_IO_NONE: assert property (busIoRead && ioWindowBaseSelect == 8'h00 |=> ioExternal)
    else $error("no window wrong");
  AST_IO_TOP: assert property (busIoRead && busAddress[7:0] == 8'hFF |=> ioExternal)
    else $error("top address wrong");
  AST_STROBE: assert property (portWr ##1 !busIoWrite |-> parallelOutputStrobe ##1
    !parallelOutputStrobe) else $error("strobe wrong");
  AST_CARD_SEL: assert property (csWr |=> spiCardSelectN == $past(busDataIn[0]))
    else $error("card select wrong");
endmodule
bind bus_card_memory_io_decode bus_card_checker #(.SPI_DIVIDE(SPI_DIVIDE)) i_chk (.*);
`default_nettype wire

// file: bench/bus_card_memory_io_decode_bench.sv
// Self-checking bench for the bus card decode block.
`timescale 1ns/100ps
`default_nettype none
module bus_card_memory_io_decode_bench;
  import bus_card_pkg::*;
  // ==========================================================================
  // Stimulus, tasks and sequence
  logic core_clk = 1'b0, reset = 1'b1, masterSlaveSelect = 1'b1;
  logic frontPanelVariantSelect = 1'b0, externalMemorySelect = 1'b1;
  logic shadowKillSourceSelect = 1'b0, spiMiso, spiMosi, spiClock, spiCardSelectN;
  logic busMemRead = 1'b0, busMemWrite = 1'b0, busIoRead = 1'b0, busIoWrite = 1'b0;
  logic [7:0] blockRamEnable = 8'h0A, blockRomEnable = 8'h4C, ioWindowBaseSelect = 8'h01;
  logic [7:0] busDataIn = 8'h00, parallelInputConnector = 8'h5A, txByte = 8'hA5;
  logic [7:0] readData, parallelOutputConnector, rxByte, b;
  logic [15:0] busAddress = 16'h0000;
  logic [14:0] memAddress;
  logic [2:0] serialRegIndex;
  logic ramSelect, ramWrite, romSelect, memExternal, serialPortFirst, serialPortSecond;
  logic ioExternal, readDataValid, parallelOutputStrobe, processorHold;
  logic dataInBufferEnable, dataOutBufferEnable, dataBufferToBus;
  logic [3:0] memExp [4] = '{4'h8, 4'h4, 4'h2, 4'h2};
  int failures = 0, checked = 0;
  always #2 core_clk = ~core_clk;
  bus_card_memory_io_decode #(.SPI_DIVIDE(8'h01)) i_dut (.*);
  spi_card_model i_card (.spiClock, .spiMosi, .spiCardSelectN, .txByte, .spiMiso, .rxByte);
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Kind bits are memory read, memory write, I/O read, I/O write.
  // One idle cycle first, so back-to-back calls never drive a strobe twice at once.
  task acc(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {busMemRead, busMemWrite, busIoRead, busIoWrite} = k;
    busAddress = a;
    busDataIn = d;
    @(negedge core_clk);
    {busMemRead, busMemWrite, busIoRead, busIoWrite} = 4'h0;
  endtask
  task memChk(input logic [15:0] a, input logic [3:0] e);
    acc(4'h8, a, 8'h00);
    chk("mem", e, {memExternal, ramSelect, romSelect, ramWrite});
  endtask
  task give_verdict;
    $display("Checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    chk("csel", 16'h1, spiCardSelectN);
    chk("pout", 16'h0, parallelOutputConnector);
    for (int i = 0; i < 4; i++) begin
      memChk({i[2:0], 13'h0123}, memExp[i]);
    end
    acc(4'h4, 16'h4010, 8'h00);
    chk("romw", 16'h1, {memExternal, romSelect, ramWrite});
    memChk(16'hC123, 4'h2);
    chk("mirror", 16'h4123, memAddress);
    masterSlaveSelect = 1'b0;
    memChk(16'h2000, 4'h4);
    chk("hold", 16'h1, processorHold);
    chk("bufs", 16'h3, {serialPortFirst, dataInBufferEnable, dataOutBufferEnable, dataBufferToBus});
    masterSlaveSelect = 1'b1;
    acc(4'h1, 16'h0011, 8'hFE);
    chk("csel", 16'h0, spiCardSelectN);
    memChk(16'h6000, 4'h4);
    acc(4'h1, 16'h0010, 8'h3C);
    repeat (40) @(negedge core_clk);
    chk("mosi", 16'h3C, rxByte);
    acc(4'h2, 16'h0010, 8'h00);
    chk("spird", 16'h1A5, {readDataValid, readData});
    acc(4'h1, 16'h0011, 8'h01);
    memChk(16'h6000, 4'h4);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    memChk(16'h6000, 4'h2);
    chk("csel", 16'h1, spiCardSelectN);
    shadowKillSourceSelect = 1'b1;
    acc(4'h1, 16'h0018, 8'h01);
    chk("pout", 16'h101, {parallelOutputStrobe, parallelOutputConnector});
    @(negedge core_clk);
    chk("strobe", 16'h0, parallelOutputStrobe);
    memChk(16'h6000, 4'h4);
    acc(4'h1, 16'h0018, 8'h00);
    memChk(16'h6000, 4'h2);
    acc(4'h2, 16'h0018, 8'h00);
    chk("pin", 16'h15A, {readDataValid, readData});
    for (int w = 0; w < 8; w++) begin
      ioWindowBaseSelect = 8'h01 << w;
      b = {w[2:0], 5'h00};
      acc(4'h2, {8'h00, b + 8'h03}, 8'h00);
      chk("serial_port_first", 16'h23, {serialPortFirst, serialPortSecond, ioExternal, serialRegIndex});
      acc(4'h2, {8'h00, b + 8'h0A}, 8'h00);
      chk("serial_port_second", 16'h12, {serialPortFirst, serialPortSecond, ioExternal, serialRegIndex});
      acc(4'h2, {8'h00, b ^ 8'h23}, 8'h00);
      chk("ioext", 16'h1, ioExternal);
    end
    acc(4'h2, 16'h00FF, 8'h00);
    chk("top", 16'h1, ioExternal);
    chk("bufm", 16'h6, {dataInBufferEnable, dataOutBufferEnable, dataBufferToBus});
    {frontPanelVariantSelect, externalMemorySelect} = 2'b10;
    memChk(16'hC123, 4'h2);
    chk("bufp", 16'h4, {dataInBufferEnable, dataOutBufferEnable, dataBufferToBus});
    ioWindowBaseSelect = 8'h00;
    acc(4'h2, 16'h0003, 8'h00);
    chk("none", 16'h1, {serialPortFirst, ioExternal});
    give_verdict();
  end
endmodule
`default_nettype wire

// file: bench/spi_card_model.sv
// Behavioural storage card on the serial side of the bus card.
`timescale 1ns/100ps
`default_nettype none
module spi_card_model (
  input  wire logic       spiClock,
  input  wire logic       spiMosi,
  input  wire logic       spiCardSelectN,
  input  wire logic [7:0] txByte,
  output logic            spiMiso,
  output logic [7:0]      rxByte
);
  // ==========================================================================
  // Card behaviour
  logic [2:0] bitCnt = 3'h0;
  // The device drives clock and select; the card only follows them.
  always @(posedge spiClock) rxByte <= {rxByte[6:0], spiMosi};
  always @(negedge spiClock or posedge spiCardSelectN) begin
    if (spiCardSelectN) bitCnt <= 3'h0;
    else bitCnt <= bitCnt + 3'h1;
  end
  // Pulled up while deselected, so a stale bit never passes for data.
  assign spiMiso = spiCardSelectN ? 1'b1 : txByte[3'h7 - bitCnt];
endmodule
`default_nettype wire

// file: hw/bus_card_memory_io_decode.sv
// Memory, I/O, SPI and parallel-port decode logic for the bus card.
`timescale 1ns/100ps
`include "bus_card_regs.svh"
`default_nettype none
module bus_card_memory_io_decode
  import bus_card_pkg::*;
#(
  parameter logic [7:0] SPI_DIVIDE = `SPI_DIVIDE
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        masterSlaveSelect,
  input  wire logic        frontPanelVariantSelect,
  input  wire logic        externalMemorySelect,
  input  wire logic        shadowKillSourceSelect,
  input  wire logic [7:0]  blockRamEnable,
  input  wire logic [7:0]  blockRomEnable,
  input  wire logic [7:0]  ioWindowBaseSelect,
  input  wire logic [15:0] busAddress,
  input  wire logic        busMemRead,
  input  wire logic        busMemWrite,
  input  wire logic        busIoRead,
  input  wire logic        busIoWrite,
  input  wire logic [7:0]  busDataIn,
  input  wire logic [7:0]  parallelInputConnector,
  input  wire logic        spiMiso,
  output logic             ramSelect,
  output logic             ramWrite,
  output logic             romSelect,
  output logic [14:0]      memAddress,
  output logic             memExternal,
  output logic             serialPortFirst,
  output logic             serialPortSecond,
  output logic [2:0]       serialRegIndex,
  output logic             ioExternal,
  output logic [7:0]       readData,
  output logic             readDataValid,
  output logic [7:0]       parallelOutputConnector,
  output logic             parallelOutputStrobe,
  output logic             spiClock,
  output logic             spiMosi,
  output logic             spiCardSelectN,
  output logic             processorHold,
  output logic             dataInBufferEnable,
  output logic             dataOutBufferEnable,
  output logic             dataBufferToBus
);
  // ========================================================================
  // Decode functions
  function automatic mem_steer_t memDecode(input mem_cfg_t cfg, input logic shadowOn,
                                           input logic rd, input logic wr);
    mem_steer_t s;
    s = '0;
    case (cfg)
      MEM_EXTERNAL: s.external = rd | wr;
      MEM_RAM: begin
        s.ramSelect = rd | wr;
        s.ramWrite = wr;
      end
      MEM_ROM: begin
        s.romSelect = rd;
        s.ramSelect = wr;
        s.ramWrite = wr;
      end
      MEM_SHADOW: begin
        s.romSelect = rd & shadowOn;
        s.ramSelect = wr | (rd & ~shadowOn);
        s.ramWrite = wr;
      end
      default: s = '0;
    endcase
    return s;
  endfunction

  function automatic logic inWindow(input logic [7:0] sel, input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (sel[i] && addr[7:5] == 3'(i)) begin
        hit = 1'b1;
      end
    end
    if (sel[`TOP_WINDOW_INDEX] && addr == `WINDOW_EXCLUDED_ADDR) begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // ========================================================================
  // Combinational decode
  // Decoding looks only at bus-side strobes, so the same logic serves a
  // cycle we originate and one an external processor drives.
  logic       shadowOn;
  logic [2:0] block;
  mem_cfg_t   blockCfg;
  mem_steer_t memSteer;
  logic       ioHit;
  logic       ioCycle;
  logic [4:0] ioOffset;
  io_steer_t  ioSteer;
  logic       spiWrite;
  logic       spiRead;
  logic       cardWrite;
  logic       portWrite;
  logic       portRead;

  assign block = busAddress[15:13];
  assign blockCfg = mem_cfg_t'({blockRomEnable[block], blockRamEnable[block]});
  assign ioOffset = busAddress[4:0];

  logic killFlag_reg;
  logic killFlag_next;
  logic cardSelect_reg;
  logic cardSelect_next;
  logic [7:0] portOut_reg;
  logic [7:0] portOut_next;

  always_comb begin
    if (shadowKillSourceSelect) begin
      shadowOn = ~portOut_reg[`SHADOW_KILL_BIT];
    end else begin
      shadowOn = ~killFlag_reg;
    end
    memSteer = memDecode(blockCfg, shadowOn, busMemRead, busMemWrite);
    ioHit = inWindow(ioWindowBaseSelect, busAddress[7:0]);
    // The window looks at the low address byte only, so without an I/O strobe
    // a memory cycle could land in it and give a UART a stray select.
    ioCycle = busIoRead | busIoWrite;
    ioSteer = '0;
    ioSteer.external = ioCycle & ~ioHit;
    if (ioHit && ioCycle && ioOffset[4] == 1'b0) begin
      ioSteer.serialFirst = ~ioOffset[`SERIAL_SECOND_BIT];
      ioSteer.serialSecond = ioOffset[`SERIAL_SECOND_BIT];
    end
    spiWrite = ioHit & busIoWrite & (ioOffset == `SPI_SHIFT_DATA_OFS);
    spiRead = ioHit & busIoRead & (ioOffset == `SPI_SHIFT_DATA_OFS);
    cardWrite = ioHit & busIoWrite & (ioOffset == `CARD_SELECT_LATCH_OFS);
    portWrite = ioHit & busIoWrite & (ioOffset == `PARALLEL_IN_OUT_PORT_OFS);
    portRead = ioHit & busIoRead & (ioOffset == `PARALLEL_IN_OUT_PORT_OFS);
  end

  // ========================================================================
  // Card select, shadow kill and parallel port
  always_comb begin
    cardSelect_next = cardSelect_reg;
    killFlag_next = killFlag_reg;
    portOut_next = portOut_reg;
    if (cardWrite) begin
      cardSelect_next = busDataIn[0];
      if (!busDataIn[0] && !shadowKillSourceSelect) begin
        killFlag_next = 1'b1;
      end
    end
    if (portWrite) begin
      portOut_next = busDataIn;
    end
  end

  // Reset re-arms the shadow, whichever source kills it.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      killFlag_reg <= 1'b0;
      cardSelect_reg <= `CARD_SELECT_RESET;
      portOut_reg <= `PARALLEL_OUT_RESET;
    end else begin
      killFlag_reg <= killFlag_next;
      cardSelect_reg <= cardSelect_next;
      portOut_reg <= portOut_next;
    end
  end

  // ========================================================================
  // SPI master
  // The serial clock is a divided core clock standing in for the slow
  // processor clock; the divider is a parameter so it can be retuned.
  spi_state_t spiState_reg;
  spi_state_t spiState_next;
  logic [7:0] spiShift_reg;
  logic [7:0] spiShift_next;
  logic [3:0] spiBits_reg;
  logic [3:0] spiBits_next;
  logic [7:0] spiDiv_reg;
  logic [7:0] spiDiv_next;
  logic       spiClk_reg;
  logic       spiClk_next;
  logic       spiMosi_reg;
  logic       spiMosi_next;
  logic       spiTick;

  assign spiTick = (spiDiv_reg == 8'h00);

  always_comb begin
    spiState_next = spiState_reg;
    spiShift_next = spiShift_reg;
    spiBits_next = spiBits_reg;
    spiClk_next = spiClk_reg;
    spiMosi_next = spiMosi_reg;
    spiDiv_next = spiTick ? SPI_DIVIDE : spiDiv_reg - 8'h01;
    case (spiState_reg)
      SPI_IDLE: begin
        spiClk_next = 1'b0;
        if (spiWrite) begin
          spiShift_next = busDataIn;
          spiMosi_next = busDataIn[7];
          spiBits_next = `SPI_BIT_COUNT;
          spiDiv_next = SPI_DIVIDE;
          spiState_next = SPI_LOW;
        end
      end
      SPI_LOW: begin
        if (spiTick) begin
          spiClk_next = 1'b1;
          spiShift_next = {spiShift_reg[6:0], spiMiso};
          spiState_next = SPI_HIGH;
        end
      end
      SPI_HIGH: begin
        if (spiTick) begin
          spiClk_next = 1'b0;
          spiMosi_next = spiShift_reg[7];
          spiBits_next = spiBits_reg - 4'h1;
          spiState_next = (spiBits_reg == 4'h1) ? SPI_IDLE : SPI_LOW;
        end
      end
      default: spiState_next = SPI_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      spiState_reg <= SPI_IDLE;
      spiShift_reg <= 8'h00;
      spiBits_reg <= 4'h0;
      spiDiv_reg <= 8'h00;
      spiClk_reg <= 1'b0;
      spiMosi_reg <= 1'b0;
    end else begin
      spiState_reg <= spiState_next;
      spiShift_reg <= spiShift_next;
      spiBits_reg <= spiBits_next;
      spiDiv_reg <= spiDiv_next;
      spiClk_reg <= spiClk_next;
      spiMosi_reg <= spiMosi_next;
    end
  end

  // ========================================================================
  // Registered outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ramSelect <= 1'b0;
      ramWrite <= 1'b0;
      romSelect <= 1'b0;
      memAddress <= 15'h0000;
      memExternal <= 1'b0;
      serialPortFirst <= 1'b0;
      serialPortSecond <= 1'b0;
      serialRegIndex <= 3'h0;
      ioExternal <= 1'b0;
      readData <= 8'h00;
      readDataValid <= 1'b0;
      parallelOutputConnector <= 8'h00;
      parallelOutputStrobe <= 1'b0;
      spiClock <= 1'b0;
      spiMosi <= 1'b0;
      spiCardSelectN <= 1'b1;
      processorHold <= 1'b0;
      dataInBufferEnable <= 1'b0;
      dataOutBufferEnable <= 1'b0;
      dataBufferToBus <= 1'b0;
    end else begin
      ramSelect <= memSteer.ramSelect;
      ramWrite <= memSteer.ramWrite;
      romSelect <= memSteer.romSelect;
      memAddress <= busAddress[14:0];
      memExternal <= memSteer.external;
      serialPortFirst <= ioSteer.serialFirst;
      serialPortSecond <= ioSteer.serialSecond;
      serialRegIndex <= ioOffset[2:0];
      ioExternal <= ioSteer.external;
      readData <= portRead ? parallelInputConnector : spiShift_reg;
      readDataValid <= portRead | spiRead;
      parallelOutputConnector <= portOut_next;
      parallelOutputStrobe <= portWrite;
      spiClock <= spiClk_reg;
      spiMosi <= spiMosi_reg;
      spiCardSelectN <= cardSelect_next;
      processorHold <= ~masterSlaveSelect;
      // In master mode, a cycle that goes to the external bus, or any cycle under the alternate panel wiring
      // with externalMemorySelect low, keeps the inbound buffer open; slave mode shuts it and reverses the outbound buffer and direction.
      dataBufferToBus <= masterSlaveSelect ? busMemWrite | busIoWrite
                                           : busMemRead | busIoRead;
      dataInBufferEnable <= masterSlaveSelect
                            & (memSteer.external | ioSteer.external
                               | (frontPanelVariantSelect & ~externalMemorySelect));
      dataOutBufferEnable <= ~masterSlaveSelect
                             ? (memSteer.ramSelect | memSteer.romSelect | (ioHit & ioCycle))
                             : (busMemWrite | busIoWrite | externalMemorySelect);
    end
  end
endmodule
`default_nettype wire

// file: hw/bus_card_pkg.sv
// Types for the bus card memory and I/O decode block.
`default_nettype none
package bus_card_pkg;
  typedef enum logic [1:0] {
    MEM_EXTERNAL = 2'b00,
    MEM_RAM      = 2'b01,
    MEM_ROM      = 2'b10,
    MEM_SHADOW   = 2'b11
  } mem_cfg_t;
  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_LOW   = 2'b01,
    SPI_HIGH  = 2'b10
  } spi_state_t;
  typedef struct packed {
    logic ramSelect;
    logic ramWrite;
    logic romSelect;
    logic external;
  } mem_steer_t;
  typedef struct packed {
    logic serialFirst;
    logic serialSecond;
    logic external;
  } io_steer_t;
endpackage
`default_nettype wire

// file: hw/bus_card_regs.svh
// Constants for the bus card memory and I/O decode block.
// ==========================================================================
// Functional notes
// - Four configurations: master or slave, two panels.
// - Decode uses bus-side address and control signals.
// - Memory split into 8K blocks, per-block enables.
// - 32K ROM mirrored, top address bit ignored.
// - No enables goes external; RAM-only serves RAM.
// - ROM-only reads ROM, writes RAM, RAM unreadable.
// - Both enables: shadow ROM until killed, then RAM.
// - Shadow ROM active after every system reset.
// - Card-select source: first select kills shadow.
// - Port source: output bit 0 kills shadow.
// - Reset clears parallel output port to zero.
// - One-hot base picks 32-address onboard I/O window.
// - No base selected: all I/O goes external.
// - Top window excludes address 0xFF from onboard decode.
// - Offsets 0-7 first serial, 8-F second.
// - Offset 0x10 write loads and starts SPI.
// - Offset 0x11 latches lsb; 0 selects card.
// - Reset sets card-select latch and clears the kill.
// - Software cannot clear the card-select kill.
// - Offset 0x18 reads input, writes output port.
// - Slave mode holds processor off, reverses buffers.
// - Buffer steering from mode, panel, external memory.
// - SPI master clocked from processor clock; code uses a divided core_clk instead.
// - Each output port write pulses a strobe.
`ifndef BUS_CARD_REGS_SVH
`define BUS_CARD_REGS_SVH
`define SPI_SHIFT_DATA_OFS        5'h10
`define CARD_SELECT_LATCH_OFS     5'h11
`define PARALLEL_IN_OUT_PORT_OFS  5'h18
`define SERIAL_SECOND_BIT         3
`define WINDOW_EXCLUDED_ADDR      8'hFF
`define TOP_WINDOW_INDEX          7
`define CARD_SELECT_RESET         1'b1
`define PARALLEL_OUT_RESET        8'h00
`define SHADOW_KILL_BIT           0
`define SPI_BIT_COUNT             4'h8
`define SPI_DIVIDE                8'h3E
`endif
